// *** pkg/aqm_pkg.sv ***
`default_nettype none
package aqm_pkg;
	localparam int NQ = 4;
	localparam int NR = 4;
	localparam int RW = 4;
	typedef enum logic [1:0] {TR_NONE, TR_DOT1P, TR_PREC, TR_DSCP} aqm_trust_t;
	typedef enum logic [1:0] {OP_ANY, OP_NE, OP_LT, OP_GT} aqm_op_t;
	localparam logic [1:0] C_RED = 2'h2;
	localparam logic [1:0] C_ANY_RED = 2'h3;
	localparam logic [7:0] FRAG_HDR = 8'h2c;
	localparam logic [7:0] QMAX = 8'hff;
	localparam logic [15:0] CR_UNIT = 16'h0100;
	localparam logic [15:0] CR_CAP = 16'hff00;
	// byte offsets
	localparam logic [11:0] A_GCTL = 12'h000;
	localparam logic [11:0] A_TRUST = 12'h004;
	localparam logic [11:0] A_PMAP = 12'h008;
	localparam logic [11:0] A_STAT = 12'h00c;
	localparam logic [11:0] A_DROPS = 12'h010;
	localparam logic [11:0] A_DSCP = 12'h020;
	localparam logic [11:0] A_QCFG = 12'h040;
	localparam logic [11:0] A_THR = 12'h080;
	localparam logic [11:0] A_RULE = 12'h100;
	// field positions
	localparam int G_IFOVR = 4;
	localparam int G_IFWRED = 5;
	localparam int T_W = 8;
	localparam int T_DEF = 2;
	localparam int Q_WGT = 0;
	localparam int Q_WRED = 1;
	localparam int Q_ECN = 2;
	localparam int Q_MIN = 8;
	localparam int Q_MAX = 16;
	localparam int H_MIN = 8;
	localparam int H_MAX = 16;
	localparam int H_PRB = 24;
	localparam int R_EN = 8;
	localparam int R_DIR = 9;
	localparam int R_SOP = 10;
	localparam int R_DOP = 12;
	localparam int R_DENY = 14;
	localparam int R_RATE = 15;
	localparam int R_QEN = 16;
	localparam int R_Q = 17;
	localparam int R_HI = 16;
	localparam int R_ICD = 8;
	localparam int R_FLG = 16;
	localparam int R_EST = 22;
	localparam int R_FRAG = 23;
	localparam int R_RTD = 24;
	localparam int R_ITE = 25;
	localparam int R_ICE = 26;
	localparam int F_RST = 2;
	localparam int F_ACK = 4;
	// reset values
	localparam logic [31:0] GCTL_RST = 32'h00000004;
	localparam logic [31:0] PMAP_RST = 32'h0000fa50;
	localparam logic [31:0] QCFG_RST = 32'h00ff0000;
	localparam logic [31:0] THR_RST = 32'h80c040ff;
	localparam logic [31:0] DSCP_RST [4] = '{32'h00000000, 32'h55555555,
		32'haaaaaaaa, 32'hffffffff};
endpackage
`default_nettype wire

// *** rtl/aqm_top.sv ***
// What this block does
// - rate-limit rules pass conforming, drop excess
// - outbound rules need egress classifier stage
// - ipv6 fragment qualifier, next header 44
// - l4 port ne, lt, gt per rule
// - established matches ack or rst set
// - each tcp flag matchable as set
// - icmp type, code and routed ipv6 match
// - lowest sequence number rule wins
// - ecn queues mark instead of drop
// - per-colour thresholds applied by packet colour
// - green, yellow, red drop precedence grading
// - hold until granted, drop when full
// - priority to queue through mapping table
// - port trusts dot1p, precedence or dscp
// - untrusted port uses default priority
// - non-ip falls back to default priority
// - per-queue strict/weighted, min and max bandwidth
// - tail drop or wred per queue
// - interface decay exponent and drop method
// - queue number below queue count
//
// Our own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module aqm_top #(
	parameter bit EGRESS_CLASSIFIER_STAGE = 1'b1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// classified packet in
	input wire logic pkt_valid,
	input wire logic pkt_egress,
	input wire logic [1:0] pkt_port,
	input wire logic [15:0] pkt_len,
	input wire logic [1:0] pkt_color,
	input wire logic pkt_ect,
	input wire logic pkt_is_ip,
	input wire logic pkt_is_ipv6,
	input wire logic pkt_routed,
	input wire logic [7:0] pkt_next_hdr,
	input wire logic pkt_has_l4,
	input wire logic pkt_is_tcp,
	input wire logic pkt_is_icmp,
	input wire logic [15:0] pkt_src_port,
	input wire logic [15:0] pkt_dst_port,
	input wire logic [5:0] pkt_tcp_flags,
	input wire logic [7:0] pkt_icmp_type,
	input wire logic [7:0] pkt_icmp_code,
	input wire logic [2:0] pkt_vlan_pri,
	input wire logic [5:0] pkt_dscp,
	// decision out
	output logic dec_valid,
	output logic [1:0] dec_queue,
	output logic [1:0] dec_color,
	output logic dec_drop,
	output logic dec_ecn,
	output logic dec_hit,
	output logic [1:0] dec_rule,
	// egress scheduler grant
	output logic tx_valid,
	output logic [1:0] tx_queue,
	input wire logic tx_ready
);
	localparam int NQ = aqm_pkg::NQ;
	localparam int NR = aqm_pkg::NR;
	localparam int RW = aqm_pkg::RW;

	logic [31:0] gctl, trust_w, pmap, drops, rd_val;
	logic [31:0] dscp_m [4];
	logic [31:0] qcfg [NQ];
	logic [31:0] thr [NQ*4];
	logic [31:0] rule_w [NR*RW];
	logic [7:0] depth [NQ];
	logic [15:0] avg [NQ];
	logic [15:0] mx_cr [NQ];
	logic [15:0] mn_cr [NQ];
	logic [15:0] bucket [NR];
	logic [15:0] lfsr;
	logic [NR-1:0] hit;
	logic [NQ-1:0] elig, guar;
	logic wr_pend, win_hit, acl_q, rate_drop, full_c, cong_c, mark_c, drop_c;
	logic grant, pick_ok, wred_sel;
	logic [11:0] wr_addr;
	logic [1:0] win, q_c, def_q, map_q, ci, pick, rr;
	logic [2:0] pri;
	logic [7:0] tw, ai, wmin, wmax, prb;
	logic [31:0] th;
	logic [15:0] p_l, p_r;
	aqm_pkg::aqm_trust_t tr;

	// saturating credit step shared by shapers and policers
	function automatic logic [15:0] cr_step(input logic [15:0] cur, input logic [15:0] add,
		input logic [15:0] cap, input logic [15:0] sub, input logic take);
		logic [16:0] s;
		s = {1'b0, cur} + {1'b0, add};
		if (s > {1'b0, cap}) s = {1'b0, cap};
		if (take) s = (s >= {1'b0, sub}) ? s - {1'b0, sub} : '0;
		return s[15:0];
	endfunction

	// l4 port comparison against the rule operand
	function automatic logic port_ok(input logic [1:0] op, input logic [15:0] v,
		input logic [15:0] k);
		unique case (aqm_pkg::aqm_op_t'(op))
			aqm_pkg::OP_ANY: return 1'b1;
			aqm_pkg::OP_NE: return pkt_has_l4 && v != k;
			aqm_pkg::OP_LT: return pkt_has_l4 && v < k;
			aqm_pkg::OP_GT: return pkt_has_l4 && v > k;
		endcase
	endfunction

	// bus: zero wait, word accesses only, others ignored
	wire acc = hsel && hready && htrans[1] && hsize == 3'h2;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_pend <= 1'b0;
			wr_addr <= '0;
			hrdata <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend <= acc && hwrite;
			if (acc) wr_addr <= haddr[11:0];
			hrdata <= (acc && !hwrite) ? rd_val : '0;
		end
	end

	// read mux; unmapped reads return zero
	always_comb begin
		rd_val = '0;
		if (haddr[11:0] == aqm_pkg::A_GCTL) rd_val = gctl;
		else if (haddr[11:0] == aqm_pkg::A_TRUST) rd_val = trust_w;
		else if (haddr[11:0] == aqm_pkg::A_PMAP) rd_val = pmap;
		else if (haddr[11:0] == aqm_pkg::A_DROPS) rd_val = drops;
		else if (haddr[11:0] == aqm_pkg::A_STAT) begin
			for (int q = 0; q < NQ; q++) rd_val[q*8 +: 8] = depth[q];
		end else if (haddr[11:4] == aqm_pkg::A_DSCP[11:4]) rd_val = dscp_m[haddr[3:2]];
		else if (haddr[11:4] == aqm_pkg::A_QCFG[11:4]) rd_val = qcfg[haddr[3:2]];
		else if (haddr[11:6] == aqm_pkg::A_THR[11:6]) rd_val = thr[haddr[5:2]];
		else if (haddr[11:6] == aqm_pkg::A_RULE[11:6]) rd_val = rule_w[haddr[5:2]];
	end

	// configuration registers, written in the data phase
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			gctl <= aqm_pkg::GCTL_RST;
			trust_w <= '0;
			pmap <= aqm_pkg::PMAP_RST;
			for (int i = 0; i < 4; i++) dscp_m[i] <= aqm_pkg::DSCP_RST[i];
			for (int i = 0; i < NQ; i++) qcfg[i] <= aqm_pkg::QCFG_RST;
			for (int i = 0; i < NQ*4; i++) thr[i] <= aqm_pkg::THR_RST;
			for (int i = 0; i < NR*RW; i++) rule_w[i] <= '0;
		end else if (wr_pend) begin
			if (wr_addr == aqm_pkg::A_GCTL) gctl <= hwdata;
			if (wr_addr == aqm_pkg::A_TRUST) trust_w <= hwdata;
			if (wr_addr == aqm_pkg::A_PMAP) pmap <= hwdata;
			if (wr_addr[11:4] == aqm_pkg::A_DSCP[11:4]) dscp_m[wr_addr[3:2]] <= hwdata;
			if (wr_addr[11:4] == aqm_pkg::A_QCFG[11:4]) qcfg[wr_addr[3:2]] <= hwdata;
			if (wr_addr[11:6] == aqm_pkg::A_THR[11:6]) thr[wr_addr[5:2]] <= hwdata;
			if (wr_addr[11:6] == aqm_pkg::A_RULE[11:6]) rule_w[wr_addr[5:2]] <= hwdata;
		end
	end

	// per-rule qualifiers and policer
	for (genvar g = 0; g < NR; g++) begin : g_rule
		wire [31:0] w0 = rule_w[g*RW];
		wire [31:0] w1 = rule_w[g*RW+1];
		wire [31:0] w2 = rule_w[g*RW+2];
		wire [31:0] w3 = rule_w[g*RW+3];
		wire [5:0] fm = w2[aqm_pkg::R_FLG +: 6];
		wire tcp_ok = ((pkt_tcp_flags & fm) == fm) && (fm == '0 || pkt_is_tcp);
		wire est_ok = !w2[aqm_pkg::R_EST] || (pkt_is_tcp &&
			(pkt_tcp_flags[aqm_pkg::F_ACK] || pkt_tcp_flags[aqm_pkg::F_RST]));
		wire frag_ok = !w2[aqm_pkg::R_FRAG] ||
			(pkt_is_ipv6 && pkt_next_hdr == aqm_pkg::FRAG_HDR);
		wire icmp_ok = (!w2[aqm_pkg::R_RTD] || (pkt_is_ipv6 && pkt_routed)) &&
			(!w2[aqm_pkg::R_ITE] || (pkt_is_icmp && pkt_icmp_type == w2[7:0])) &&
			(!w2[aqm_pkg::R_ICE] || (pkt_is_icmp &&
			pkt_icmp_code == w2[aqm_pkg::R_ICD +: 8]));
		wire l4_ok = port_ok(w0[aqm_pkg::R_SOP +: 2], pkt_src_port, w1[15:0]) &&
			port_ok(w0[aqm_pkg::R_DOP +: 2], pkt_dst_port, w1[aqm_pkg::R_HI +: 16]);
		// outbound rules exist only with an egress classifier stage
		wire dir_ok = w0[aqm_pkg::R_DIR] == pkt_egress &&
			(!w0[aqm_pkg::R_DIR] || EGRESS_CLASSIFIER_STAGE);
		assign hit[g] = w0[aqm_pkg::R_EN] && dir_ok && tcp_ok && est_ok && frag_ok &&
			icmp_ok && l4_ok;
		wire take = pkt_valid && win_hit && win == 2'(g) && w0[aqm_pkg::R_RATE] &&
			!rate_drop;
		// token bucket refills every cycle, burst caps it
		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) bucket[g] <= '0;
			else bucket[g] <= cr_step(bucket[g], w3[15:0], w3[aqm_pkg::R_HI +: 16],
				pkt_len, take);
		end
	end

	// winner is the matching rule with the smallest sequence number
	always_comb begin
		win_hit = 1'b0;
		win = '0;
		for (int r = 0; r < NR; r++) begin
			if (hit[r] && (!win_hit || rule_w[r*RW][7:0] < rule_w[win*RW][7:0])) begin
				win_hit = 1'b1;
				win = 2'(r);
			end
		end
	end

	// trusted field or port default picks the priority
	always_comb begin
		tw = trust_w[pkt_port*aqm_pkg::T_W +: aqm_pkg::T_W];
		tr = aqm_pkg::aqm_trust_t'(tw[1:0]);
		def_q = pmap[tw[aqm_pkg::T_DEF +: 3]*2 +: 2];
		pri = tw[aqm_pkg::T_DEF +: 3];
		map_q = def_q;
		unique case (tr)
			aqm_pkg::TR_NONE: map_q = def_q;
			aqm_pkg::TR_DOT1P: map_q = pmap[pkt_vlan_pri*2 +: 2];
			aqm_pkg::TR_PREC: begin
				if (pkt_is_ip) map_q = pmap[pkt_dscp[5:3]*2 +: 2];
				else map_q = def_q;
			end
			aqm_pkg::TR_DSCP: begin
				if (pkt_is_ip) map_q = dscp_m[pkt_dscp[5:4]][pkt_dscp[3:0]*2 +: 2];
				else map_q = def_q;
			end
		endcase
		acl_q = win_hit && rule_w[win*RW][aqm_pkg::R_QEN] && !rule_w[win*RW][aqm_pkg::R_DENY];
		q_c = acl_q ? rule_w[win*RW][aqm_pkg::R_Q +: 2] : map_q; // two bits
	end

	// colour picks the threshold set; code 3 is graded red
	assign ci = (pkt_color == aqm_pkg::C_ANY_RED) ? aqm_pkg::C_RED : pkt_color;
	assign th = thr[{q_c, ci}];
	assign ai = avg[q_c][15:8];
	assign wmin = th[aqm_pkg::H_MIN +: 8];
	assign wmax = th[aqm_pkg::H_MAX +: 8];
	assign prb = th[aqm_pkg::H_PRB +: 8];
	// linear ramp compared without a divider
	assign p_l = lfsr[7:0] * (wmax - wmin);
	assign p_r = prb * (ai - wmin);
	assign wred_sel = gctl[aqm_pkg::G_IFOVR] ? gctl[aqm_pkg::G_IFWRED] :
		qcfg[q_c][aqm_pkg::Q_WRED];

	// drop and mark decision for the arriving packet
	always_comb begin
		full_c = depth[q_c] >= aqm_pkg::QMAX;
		if (wred_sel) cong_c = ai >= wmax || (ai >= wmin && p_l < p_r);
		else cong_c = depth[q_c] >= th[7:0];
		mark_c = cong_c && !full_c && pkt_ect && qcfg[q_c][aqm_pkg::Q_ECN];
		rate_drop = win_hit && rule_w[win*RW][aqm_pkg::R_RATE] &&
			bucket[win] < pkt_len;
		drop_c = full_c || (cong_c && !mark_c) || rate_drop ||
			(win_hit && rule_w[win*RW][aqm_pkg::R_DENY]);
	end

	// decision register, one cycle after the packet
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dec_valid <= 1'b0;
			dec_queue <= '0;
			dec_color <= '0;
			dec_drop <= 1'b0;
			dec_ecn <= 1'b0;
			dec_hit <= 1'b0;
			dec_rule <= '0;
		end else begin
			dec_valid <= pkt_valid;
			dec_queue <= q_c;
			dec_color <= ci;
			dec_drop <= pkt_valid && drop_c;
			dec_ecn <= pkt_valid && mark_c && !drop_c; // no mark on a packet denied or policed
			dec_hit <= pkt_valid && win_hit;
			dec_rule <= win;
		end
	end

	// drop counter; a drop in the clearing cycle still counts
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) drops <= '0;
		else if (pkt_valid && drop_c)
			drops <= ((wr_pend && wr_addr == aqm_pkg::A_DROPS) ? '0 : drops) + 32'h1;
		else if (wr_pend && wr_addr == aqm_pkg::A_DROPS) drops <= '0;
	end

	// noise source for the wred ramp
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) lfsr <= 16'hace1;
		else lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
	end

	// per-queue depth, averaged depth and shaper credits
	for (genvar g = 0; g < NQ; g++) begin : g_q
		wire enq = pkt_valid && !drop_c && q_c == 2'(g);
		wire deq = grant && tx_queue == 2'(g);
		wire signed [16:0] dlt = $signed({1'b0, depth[g], 8'h00}) - $signed({1'b0, avg[g]});
		assign elig[g] = depth[g] != '0 && mx_cr[g] >= aqm_pkg::CR_UNIT;
		assign guar[g] = elig[g] && mn_cr[g] >= aqm_pkg::CR_UNIT;
		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) depth[g] <= '0;
			else depth[g] <= depth[g] + {7'h0, enq} - {7'h0, deq};
		end
		// exponential average keeps short bursts out of wred
		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) avg[g] <= '0;
			else avg[g] <= avg[g] + 16'(dlt >>> gctl[3:0]);
		end
		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				mx_cr[g] <= '0;
				mn_cr[g] <= '0;
			end else begin
				mx_cr[g] <= cr_step(mx_cr[g], {8'h0, qcfg[g][aqm_pkg::Q_MAX +: 8]},
					aqm_pkg::CR_CAP, aqm_pkg::CR_UNIT, deq);
				mn_cr[g] <= cr_step(mn_cr[g], {8'h0, qcfg[g][aqm_pkg::Q_MIN +: 8]},
					aqm_pkg::CR_CAP, aqm_pkg::CR_UNIT, deq);
			end
		end
	end

	// guaranteed first, then strict by index, then round robin
	always_comb begin
		pick_ok = 1'b0;
		pick = '0;
		for (int q = NQ - 1; q >= 0; q--) begin
			if (!pick_ok && guar[q]) begin
				pick_ok = 1'b1;
				pick = 2'(q);
			end
		end
		for (int q = NQ - 1; q >= 0; q--) begin
			if (!pick_ok && elig[q] && !qcfg[q][aqm_pkg::Q_WGT]) begin
				pick_ok = 1'b1;
				pick = 2'(q);
			end
		end
		for (int k = 1; k <= NQ; k++) begin
			if (!pick_ok && elig[2'(rr + 2'(k))]) begin
				pick_ok = 1'b1;
				pick = 2'(rr + 2'(k));
			end
		end
	end

	assign grant = tx_valid && tx_ready;
	// offer held until taken; idle cycle after a grant avoids a stale pick
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_valid <= 1'b0;
			tx_queue <= '0;
			rr <= '0;
		end else if (grant) begin
			tx_valid <= 1'b0;
			if (qcfg[tx_queue][aqm_pkg::Q_WGT]) rr <= tx_queue;
		end else if (!tx_valid && pick_ok) begin
			tx_valid <= 1'b1;
			tx_queue <= pick;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	untrusted_queue_a: assert property (pkt_valid && tr == aqm_pkg::TR_NONE && !acl_q |=>
		dec_queue == $past(def_q)) else $error("untrusted port left default queue");
	nonip_fallback_a: assert property (pkt_valid && !pkt_is_ip && !acl_q &&
		(tr == aqm_pkg::TR_PREC || tr == aqm_pkg::TR_DSCP) |=> dec_queue == $past(def_q))
		else $error("non-ip packet did not fall back");
	full_drop_a: assert property (pkt_valid && depth[q_c] == aqm_pkg::QMAX |=> dec_drop)
		else $error("packet to full queue kept");
	deny_drop_a: assert property (pkt_valid && win_hit &&
		rule_w[win*RW][aqm_pkg::R_DENY] |=> dec_drop && dec_hit) else $error("deny not dropped");
	grant_hold_a: assert property (tx_valid && !tx_ready |=>
		tx_valid && $stable(tx_queue)) else $error("offer withdrawn before grant");
	grant_gap_a: assert property (grant |=> !tx_valid) else $error("no gap after grant");
	ecn_keep_a: assert property (dec_valid && dec_ecn |-> !dec_drop)
		else $error("marked packet dropped");
	depth_count_a: assert property (pkt_valid && !drop_c && q_c == '0 &&
		!(grant && tx_queue == '0) |=> depth[0] == $past(depth[0]) + 8'h01)
		else $error("queue zero depth not counted");
	tail_thr_a: assert property (pkt_valid && !wred_sel && !full_c &&
		depth[q_c] >= th[7:0] && !(pkt_ect && qcfg[q_c][aqm_pkg::Q_ECN]) |=> dec_drop)
		else $error("tail threshold ignored");
endmodule // aqm_top
`default_nettype wire

// *** sim/aqm_egress_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module aqm_egress_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// scheduler offer and grant
	input wire logic tx_valid,
	output logic tx_ready,
	// bench control: hold off, or answer lag cycles late
	input wire logic stall,
	input wire logic [1:0] lag
);
	logic [1:0] cnt;
	logic want;

	// a real port never grants before the offer stands
	assign want = tx_valid && !tx_ready && !stall;

	// grant lasts one edge, so a new offer is needed each time
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_ready <= 1'b0;
			cnt <= 2'h0;
		end else if (want && cnt == lag) begin
			tx_ready <= 1'b1;
			cnt <= 2'h0;
		end else begin
			tx_ready <= 1'b0;
			cnt <= want ? cnt + 2'h1 : 2'h0;
		end
	end
endmodule // aqm_egress_model
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	// clock, reset and register bus
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout, hresp;
	// packet descriptor, tcp and icmp flags held up
	logic pkt_valid = 1'b0, pkt_egress = 1'b0, pkt_ect = 1'b0, pkt_is_ip = 1'b1;
	logic pkt_is_ipv6 = 1'b1, pkt_routed = 1'b0, pkt_has_l4 = 1'b1;
	logic pkt_is_tcp = 1'b1, pkt_is_icmp = 1'b1;
	logic [1:0] pkt_port = 2'h0, pkt_color = 2'h0;
	logic [15:0] pkt_len = 16'h0040, pkt_src_port = 16'h0, pkt_dst_port = 16'h0;
	logic [7:0] pkt_next_hdr = 8'h0, pkt_icmp_type = 8'h0, pkt_icmp_code = 8'h0;
	logic [5:0] pkt_tcp_flags = 6'h0, pkt_dscp = 6'h0;
	logic [2:0] pkt_vlan_pri = 3'h0;
	// decisions, scheduler and far side control
	logic dec_valid, dec_drop, dec_ecn, dec_hit, tx_valid, tx_ready;
	logic [1:0] dec_queue, dec_color, dec_rule, tx_queue;
	logic stall = 1'b0;
	logic [1:0] lag = 2'h0;
	// bench state
	int errors = 0;
	int n_checks = 0;
	int grants = 0;
	int g0;
	logic [31:0] rd;
	logic d_drop, d_ecn, d_hit;
	logic [1:0] d_q, d_c, d_r;
	typedef struct packed {
		logic [1:0] port;
		logic [2:0] pri;
		logic [5:0] dscp;
		logic ip;
		logic [1:0] q;
	} aqm_map_row_t;
	typedef struct packed {
		logic [31:0] w0;
		logic [31:0] w2;
		logic [15:0] v;
		logic hit;
	} aqm_rule_row_t;
	// ports: 0 untrusted pri 5, 1 dot1p, 2 prec pri 6, 3 dscp pri 4
	aqm_map_row_t map_rows [9] = '{'{2'h0, 3'h7, 6'h3f, 1'b1, 2'h2},
		'{2'h1, 3'h6, 6'h0, 1'b1, 2'h3}, '{2'h1, 3'h2, 6'h3f, 1'b1, 2'h1},
		'{2'h2, 3'h0, 6'h3f, 1'b1, 2'h3}, '{2'h2, 3'h7, 6'h10, 1'b1, 2'h1},
		'{2'h2, 3'h7, 6'h3f, 1'b0, 2'h3}, '{2'h3, 3'h0, 6'h25, 1'b1, 2'h2},
		'{2'h3, 3'h7, 6'h05, 1'b1, 2'h0}, '{2'h3, 3'h0, 6'h3f, 1'b0, 2'h2}};
	// one qualifier per row; operands are 0x50 on both ports
	aqm_rule_row_t rule_rows [21] = '{'{32'h500, 32'h0, 16'h50, 1'b0},
		'{32'h500, 32'h0, 16'h51, 1'b1}, '{32'h900, 32'h0, 16'h4f, 1'b1},
		'{32'h900, 32'h0, 16'h50, 1'b0}, '{32'hd00, 32'h0, 16'h50, 1'b0},
		'{32'hd00, 32'h0, 16'h51, 1'b1}, '{32'h1100, 32'h0, 16'h50, 1'b0},
		'{32'h2100, 32'h0, 16'h4f, 1'b1}, '{32'h3100, 32'h0, 16'h50, 1'b0},
		'{32'h3100, 32'h0, 16'h51, 1'b1}, '{32'h100, 32'h400000, 16'h10, 1'b1},
		'{32'h100, 32'h400000, 16'h4, 1'b1}, '{32'h100, 32'h400000, 16'h2, 1'b0},
		'{32'h100, 32'h800000, 16'h2c, 1'b1}, '{32'h100, 32'h800000, 16'h2b, 1'b0},
		'{32'h100, 32'h1000000, 16'h1, 1'b1}, '{32'h100, 32'h1000000, 16'h0, 1'b0},
		'{32'h100, 32'h2000005, 16'h5, 1'b1}, '{32'h100, 32'h2000005, 16'h6, 1'b0},
		'{32'h100, 32'h4000300, 16'h3, 1'b1}, '{32'h100, 32'h4000300, 16'h2, 1'b0}};
	// fill colours and expected {drop, graded colour}
	logic [1:0] f_col [6] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h3, 2'h2};
	logic [2:0] f_exp [6] = '{3'h0, 3'h0, 3'h4, 3'h1, 3'h2, 3'h6};
	logic [1:0] e_exp [3] = '{2'h2, 2'h1, 2'h0};

	aqm_top i_dut (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .pkt_valid, .pkt_egress,
		.pkt_port, .pkt_len, .pkt_color, .pkt_ect, .pkt_is_ip, .pkt_is_ipv6,
		.pkt_routed, .pkt_next_hdr, .pkt_has_l4, .pkt_is_tcp, .pkt_is_icmp,
		.pkt_src_port, .pkt_dst_port, .pkt_tcp_flags, .pkt_icmp_type,
		.pkt_icmp_code, .pkt_vlan_pri, .pkt_dscp, .dec_valid, .dec_queue,
		.dec_color, .dec_drop, .dec_ecn, .dec_hit, .dec_rule, .tx_valid,
		.tx_queue, .tx_ready);
	aqm_egress_model i_far (.clk, .rst_b, .tx_valid, .tx_ready, .stall, .lag);

	// 200 mhz clock
	always #2.5 clk = ~clk;

	// count dequeues granted by the far side
	always @(posedge clk) begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
			grants <= grants + 1;
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t %s seen %h exp %h", $time, m, seen, exp);
		end
	endtask

	// single word transfer; every task starts and ends just after an edge
	task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {20'h0, a};
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string m);
		ahb(1'b0, a, 32'h0);
		chk(rd, exp, m);
	endtask

	// one descriptor, decision captured in the cycle it stands
	task automatic pkt();
		pkt_valid <= 1'b1;
		@(posedge clk);
		pkt_valid <= 1'b0;
		#1;
		chk(32'(dec_valid), 32'h1, "no decision");
		{d_drop, d_ecn, d_hit, d_q, d_c, d_r} = {dec_drop, dec_ecn, dec_hit, dec_queue,
			dec_color, dec_rule};
		@(posedge clk);
	endtask

	// same value on every qualifier field, rules look at one each
	task automatic setv(input logic [15:0] v);
		pkt_src_port <= v;
		pkt_dst_port <= v;
		pkt_tcp_flags <= v[5:0];
		pkt_icmp_type <= v[7:0];
		pkt_icmp_code <= v[7:0];
		pkt_next_hdr <= v[7:0];
		pkt_routed <= v[0];
	endtask

	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// watchdog, far beyond the few hundred cycles needed
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		give_verdict();
	end

	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		chk(32'({hreadyout, hresp, tx_valid, dec_valid}), 32'h8, "reset outputs");
		rdchk(aqm_pkg::A_GCTL, 32'h4, "gctl");
		rdchk(aqm_pkg::A_PMAP, 32'hfa50, "pmap");
		rdchk(12'h04c, 32'h00ff0000, "qcfg");
		rdchk(12'h0bc, 32'h80c040ff, "thr");
		rdchk(12'h024, 32'h55555555, "dscp map");
		rdchk(12'hffc, 32'h0, "unmapped");
		ahb(1'b1, aqm_pkg::A_STAT, 32'hffffffff);
		rdchk(aqm_pkg::A_STAT, 32'h0, "stat read only");
		// trust sources and defaults through the mapping table
		ahb(1'b1, aqm_pkg::A_TRUST, 32'h131a0114);
		foreach (map_rows[i]) begin
			pkt_port <= map_rows[i].port;
			pkt_vlan_pri <= map_rows[i].pri;
			pkt_dscp <= map_rows[i].dscp;
			pkt_is_ip <= map_rows[i].ip;
			pkt();
			chk(32'(d_q), 32'(map_rows[i].q), "queue map");
		end
		pkt_port <= 2'h0;
		pkt_is_ip <= 1'b1;
		// qualifier table on rule 0
		ahb(1'b1, aqm_pkg::A_RULE + 12'h4, 32'h00500050);
		foreach (rule_rows[i]) begin
			ahb(1'b1, aqm_pkg::A_RULE, rule_rows[i].w0);
			ahb(1'b1, aqm_pkg::A_RULE + 12'h8, rule_rows[i].w2);
			setv(rule_rows[i].v);
			pkt();
			chk(32'(d_hit), 32'(rule_rows[i].hit), "qualifier");
		end
		// each flag alone, then all the others without it
		for (int b = 0; b < 6; b++) begin
			ahb(1'b1, aqm_pkg::A_RULE + 12'h8, 32'h1 << (16 + b));
			setv(16'(1 << b));
			pkt();
			chk(32'(d_hit), 32'h1, "flag set");
			setv(16'(6'h3f ^ (6'h1 << b)));
			pkt();
			chk(32'(d_hit), 32'h0, "flag clear");
		end
		// lowest sequence number wins regardless of index
		ahb(1'b1, aqm_pkg::A_RULE + 12'h8, 32'h0);
		ahb(1'b1, aqm_pkg::A_RULE, 32'h00070109);
		ahb(1'b1, aqm_pkg::A_RULE + 12'h10, 32'h00030102);
		pkt();
		chk(32'({d_r, d_q}), 32'h5, "seq order");
		ahb(1'b1, aqm_pkg::A_RULE + 12'h10, 32'h00030114);
		pkt();
		chk(32'({d_r, d_q}), 32'h3, "resequenced");
		ahb(1'b1, aqm_pkg::A_RULE, 32'h00074109);
		pkt();
		chk(32'({d_hit, d_drop}), 32'h3, "deny");
		rdchk(aqm_pkg::A_DROPS, 32'h1, "drop count");
		ahb(1'b1, aqm_pkg::A_DROPS, 32'h0);
		rdchk(aqm_pkg::A_DROPS, 32'h0, "drop clear");
		// rate 0x10 per cycle, burst 0x40: one full packet then excess
		ahb(1'b1, aqm_pkg::A_RULE + 12'h10, 32'h0);
		ahb(1'b1, aqm_pkg::A_RULE + 12'hc, 32'h00400010);
		for (int e = 0; e < 2; e++) begin
			ahb(1'b1, aqm_pkg::A_RULE, 32'h8100 | (32'(e) << 9));
			pkt_egress <= e[0];
			repeat (8) @(posedge clk);
			pkt();
			chk(32'(d_drop), 32'h0, "within rate");
			pkt();
			chk(32'(d_drop), 32'h1, "over rate");
		end
		pkt_egress <= 1'b0;
		ahb(1'b1, aqm_pkg::A_RULE, 32'h0);
		// drain, stall the far side, fill queue 2 per colour
		rd = 32'h1;
		for (int k = 0; k < 50 && rd !== 32'h0; k++) begin
			ahb(1'b0, aqm_pkg::A_STAT, 32'h0);
		end
		stall <= 1'b1;
		ahb(1'b1, 12'h0a0, 32'h80c04002);
		ahb(1'b1, 12'h0a8, 32'h80c04004);
		for (int i = 0; i < 6; i++) begin
			pkt_color <= f_col[i];
			pkt();
			chk(32'({d_drop, d_c}), 32'(f_exp[i]), "colour threshold");
		end
		repeat (10) @(posedge clk);
		chk(32'({tx_valid, tx_queue}), 32'h6, "offer held");
		rdchk(aqm_pkg::A_STAT, 32'h00040000, "depth held");
		g0 = grants;
		stall <= 1'b0;
		lag <= 2'h2;
		for (int k = 0; k < 100 && grants - g0 < 4; k++) @(posedge clk);
		chk(32'(grants - g0), 32'h4, "grants");
		rdchk(aqm_pkg::A_STAT, 32'h0, "drained");
		// ecn queue 1 always congested; then interface tail drop override
		pkt_port <= 2'h1;
		pkt_vlan_pri <= 3'h2;
		pkt_color <= 2'h0;
		ahb(1'b1, 12'h044, 32'h00ff0006);
		ahb(1'b1, 12'h090, 32'h000000ff);
		for (int m = 0; m < 3; m++) begin
			if (m == 2) begin
				ahb(1'b1, aqm_pkg::A_GCTL, 32'h14);
			end
			pkt_ect <= (m == 0);
			pkt();
			chk(32'({d_ecn, d_drop}), 32'(e_exp[m]), "ecn");
		end
		// interface wred, zero probability: ramp must never drop below max
		ahb(1'b1, aqm_pkg::A_GCTL, 32'h34);
		ahb(1'b1, 12'h090, 32'h00ff0000);
		pkt();
		chk(32'({d_ecn, d_drop}), 32'h0, "zero probability ramp");
		// mid-run reset idles outputs and restores registers
		rst_b <= 1'b0;
		@(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		chk(32'({hreadyout, hresp, tx_valid, dec_valid}), 32'h8, "mid reset outputs");
		rdchk(aqm_pkg::A_GCTL, 32'h4, "gctl after reset");
		rdchk(aqm_pkg::A_STAT, 32'h0, "depth after reset");
		give_verdict();
	end
endmodule // tb_top
`default_nettype wire
